// ---- inc/gpc_params.svh ----
// Offsets, field positions, reset values and masks of the pin config bank
`ifndef GPC_PARAMS_SVH
`define GPC_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define GPC_IDX_PIN_1_1 8'h21
`define GPC_IDX_PIN_1_2 8'h22
`define GPC_IDX_PIN_1_3 8'h23
`define GPC_IDX_PIN_1_4 8'h24
`define GPC_IDX_PIN_1_5 8'h25
`define GPC_IDX_PIN_1_6 8'h26
`define GPC_IDX_PIN_1_7 8'h27
`define GPC_IDX_PIN_2_0 8'h28
`define GPC_IDX_PIN_2_1 8'h29
`define GPC_IDX_PIN_2_2 8'h2A
`define GPC_IDX_DATA_1 8'h35
`define GPC_IDX_DATA_2 8'h36

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define GPC_BIT_DIR 0
`define GPC_BIT_POL 1
`define GPC_BIT_FN_LO 2
`define GPC_BIT_FN_HI 3
`define GPC_BIT_OD 7

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define GPC_RST_GRP1 8'h01
`define GPC_RST_GRP2 8'h04
`define GPC_RST_DATA 10'h000
`define GPC_MASK_PLAIN 8'h83
`define GPC_MASK_FN1 8'h87
`define GPC_MASK_FN2 8'h8F

`endif

// ---- inc/gpc_pkg.sv ----
// Types shared by the pin config bank
package gpc_pkg;

  typedef enum logic [1:0]
  {
    GPC_IDLE = 2'b01,
    GPC_ACK = 2'b10
  } gpc_bus_e;

  typedef struct packed
  {
    logic od;
    logic [1:0] fn;
    logic pol;
    logic dir_in;
  } gpc_pin_cfg_s;

  typedef struct packed
  {
    logic fan_speed_input_1;
    logic fan_speed_input_2;
    logic display_link_data_5v;
    logic display_link_clock_5v;
    logic display_link_data_3v;
    logic edge_event_input_0;
  } gpc_alt_in_s;

endpackage

// ---- rtl/gpc_bank.sv ----
// Pin configuration bank for ten general purpose pins with Avalon-MM slave
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "gpc_params.svh"

// Function
// - Config bit 0 sets direction: one is input, zero is output.
// - Config bit 1 inverts the value between pin and data bit.
// - Config bit 7 selects open-drain, otherwise push-pull output driver.
// - Pin 1.6 bit 2 routes the pin to fan speed input 1.
// - Pin 1.7 bit 2 routes the pin to fan speed input 2.
// - Pin 2.0 bit 2 makes the pin the 5 V display data line.
// - Pin 2.1 field 3:2 picks GPIO, 5 V display clock, edge event.
// - Pin 2.2 field 3:2 picks GPIO, 3.3 V display data, edge event.
// - Pin values live in data registers; group 1 data resets to zero.
module gpc_bank
  import gpc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [9:0] pin_in,
  output logic [9:0] pin_out,
  output logic [9:0] pin_oe,
  input wire logic display_link_data_5v_low,
  input wire logic display_link_clock_5v_low,
  input wire logic display_link_data_3v_low,
  output gpc_alt_in_s alt_in
);

  // ----------------------------------------------------------------
  // Constant tables per pin (bit 0 = pin 1.1 ... bit 9 = pin 2.2)
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_IDX [10] = '{
    `GPC_IDX_PIN_1_1, `GPC_IDX_PIN_1_2, `GPC_IDX_PIN_1_3,
    `GPC_IDX_PIN_1_4, `GPC_IDX_PIN_1_5, `GPC_IDX_PIN_1_6,
    `GPC_IDX_PIN_1_7, `GPC_IDX_PIN_2_0, `GPC_IDX_PIN_2_1,
    `GPC_IDX_PIN_2_2};
  localparam logic [7:0] CFG_MASK [10] = '{
    `GPC_MASK_PLAIN, `GPC_MASK_PLAIN, `GPC_MASK_PLAIN,
    `GPC_MASK_PLAIN, `GPC_MASK_PLAIN, `GPC_MASK_FN1,
    `GPC_MASK_FN1, `GPC_MASK_FN1, `GPC_MASK_FN2,
    `GPC_MASK_FN2};
  localparam logic [7:0] CFG_RST [10] = '{
    `GPC_RST_GRP1, `GPC_RST_GRP1, `GPC_RST_GRP1,
    `GPC_RST_GRP1, `GPC_RST_GRP1, `GPC_RST_GRP1,
    `GPC_RST_GRP1, `GPC_RST_GRP2, `GPC_RST_GRP2,
    `GPC_RST_GRP2};

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  gpc_bus_e st_q;
  gpc_bus_e st_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  wire logic req_w;
  wire logic wr_fire_w;
  wire logic [7:0] idx_w;
  wire logic wbyte_w;
  wire logic [7:0] wdat_w;

  assign req_w = avs_read | avs_write;
  assign idx_w = avs_address[9:2];
  assign wbyte_w = avs_write & avs_byteenable[0];
  assign wdat_w = avs_writedata[7:0];
  // Request completes in the cycle after it is first seen
  assign avs_waitrequest = req_w & (st_q != GPC_ACK);
  assign wr_fire_w = wbyte_w & (st_q == GPC_ACK);
  assign avs_readdata = rdata_q;

  always_comb
  begin
    st_d = GPC_IDLE;
    unique case (st_q)
      GPC_IDLE:
      begin
        if (req_w)
        begin
          st_d = GPC_ACK;
        end
      end
      GPC_ACK:
      begin
        st_d = GPC_IDLE;
      end
      default:
      begin
        st_d = GPC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q <= GPC_IDLE;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers and per-pin drive
  // ----------------------------------------------------------------
  logic [7:0] cfg_q [10];
  logic [9:0] data_q;
  logic [9:0] data_d;
  wire logic [9:0] cfg_hit_w;
  wire logic [9:0] alt_on_w;
  wire logic [9:0] alt_low_w;
  wire logic [9:0] disp_mode_w;
  wire logic [9:0] logic_val_w;
  wire logic [31:0] rd_acc_w [11];
  gpc_pin_cfg_s pcfg_w [10];

  assign rd_acc_w[0] = 32'h0000_0000;
  assign alt_low_w = {display_link_data_3v_low, display_link_clock_5v_low,
                      display_link_data_5v_low, 7'h00} & disp_mode_w;

  genvar gi;
  generate
    for (gi = 0; gi < 10; gi++)
    begin : g_pin
      wire logic level_w;
      wire logic gp_drive_w;
      assign cfg_hit_w[gi] = (idx_w == CFG_IDX[gi]);
      // Stored value is already masked, so reserved bits read zero
      assign pcfg_w[gi] = '{od: cfg_q[gi][`GPC_BIT_OD],
                           fn: cfg_q[gi][`GPC_BIT_FN_HI:`GPC_BIT_FN_LO],
                           pol: cfg_q[gi][`GPC_BIT_POL],
                           dir_in: cfg_q[gi][`GPC_BIT_DIR]};
      // Field 11 is reserved and leaves the pin as GPIO
      assign alt_on_w[gi] = pcfg_w[gi].fn[0] ^ pcfg_w[gi].fn[1];
      assign disp_mode_w[gi] = pcfg_w[gi].fn == 2'b01;
      assign level_w = data_q[gi] ^ pcfg_w[gi].pol;
      assign gp_drive_w = ~pcfg_w[gi].dir_in & ~alt_on_w[gi];
      // Open drain drives low only and releases for high
      assign pin_oe[gi] = alt_on_w[gi] ? alt_low_w[gi]
                        : gp_drive_w & (~pcfg_w[gi].od | ~level_w);
      assign pin_out[gi] = ~alt_on_w[gi] & ~pcfg_w[gi].od & level_w;
      // Input pins show the pin, output pins the stored value
      assign logic_val_w[gi] = pcfg_w[gi].dir_in ?
                               (pin_in[gi] ^ pcfg_w[gi].pol)
                               : data_q[gi];
      assign rd_acc_w[gi + 1] = rd_acc_w[gi] |
                                (cfg_hit_w[gi] ? {24'h00_0000, cfg_q[gi]}
                                               : 32'h0000_0000);

      always_ff @(posedge clk_sys or negedge arst_n)
      begin
        if (!arst_n)
        begin
          cfg_q[gi] <= CFG_RST[gi];
        end
        else if (wr_fire_w && cfg_hit_w[gi])
        begin
          cfg_q[gi] <= wdat_w & CFG_MASK[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Data registers
  // ----------------------------------------------------------------
  wire logic hit_d1_w;
  wire logic hit_d2_w;
  wire logic [7:0] data1_rd_w;
  wire logic [7:0] data2_rd_w;

  assign hit_d1_w = idx_w == `GPC_IDX_DATA_1;
  assign hit_d2_w = idx_w == `GPC_IDX_DATA_2;
  // Pin 1.n sits at bit n; bit 0 belongs to a pin outside this bank
  assign data1_rd_w = {logic_val_w[6:0], 1'b0};
  assign data2_rd_w = {5'h00, logic_val_w[9:7]};

  always_comb
  begin
    data_d = data_q;
    if (wr_fire_w && hit_d1_w)
    begin
      data_d[6:0] = wdat_w[7:1];
    end
    if (wr_fire_w && hit_d2_w)
    begin
      data_d[9:7] = wdat_w[2:0];
    end
  end

  always_comb
  begin
    rdata_d = rd_acc_w[10];
    if (hit_d1_w)
    begin
      rdata_d = {24'h00_0000, data1_rd_w};
    end
    else if (hit_d2_w)
    begin
      rdata_d = {24'h00_0000, data2_rd_w};
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      data_q <= `GPC_RST_DATA;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      data_q <= data_d;
      if (avs_read && st_q == GPC_IDLE)
      begin
        rdata_q <= rdata_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // Alternate function inputs
  // ----------------------------------------------------------------
  gpc_alt_in_s alt_d;

  assign alt_d.fan_speed_input_1 = alt_on_w[5] & pin_in[5];
  assign alt_d.fan_speed_input_2 = alt_on_w[6] & pin_in[6];
  assign alt_d.display_link_data_5v = disp_mode_w[7] & pin_in[7];
  assign alt_d.display_link_clock_5v = disp_mode_w[8] & pin_in[8];
  assign alt_d.display_link_data_3v = disp_mode_w[9] & pin_in[9];
  assign alt_d.edge_event_input_0 =
    (pcfg_w[8].fn == 2'b10 & pin_in[8]) |
    (pcfg_w[9].fn == 2'b10 & pin_in[9]);

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      alt_in <= '0;
    end
    else
    begin
      alt_in <= alt_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  sequence s_cfg_write(int i, logic [7:0] v);
    wr_fire_w && cfg_hit_w[i] && wdat_w == v;
  endsequence

  dir_input_a: assert property (
    s_cfg_write(0, 8'h01) |=> !pin_oe[0])
    else $error("input pin is driven");
  dir_output_a: assert property (
    s_cfg_write(0, 8'h00) |=> pin_oe[0] && pin_out[0] == data_q[0])
    else $error("output pin not driven");
  pol_invert_a: assert property (
    s_cfg_write(0, 8'h02) |=> pin_out[0] == !data_q[0])
    else $error("polarity not inverted");
  open_drain_a: assert property (
    s_cfg_write(0, 8'h80) |=> !pin_out[0] && pin_oe[0] == !data_q[0])
    else $error("open drain drives high");
  fan_one_a: assert property (
    s_cfg_write(5, 8'h05) ##1 pin_in[5] |=> alt_in.fan_speed_input_1)
    else $error("fan input 1 not routed");
  fan_two_a: assert property (
    alt_on_w[6] |-> !pin_oe[6] && !pin_out[6])
    else $error("fan pin 2 driven");
  disp_data5_a: assert property (
    disp_mode_w[7] |-> pin_oe[7] == display_link_data_5v_low && !pin_out[7])
    else $error("display data 5v drive wrong");
  fn_reserved_a: assert property (
    pcfg_w[8].fn == 2'b11 |-> !alt_on_w[8])
    else $error("reserved function taken as alternate");
  edge_event_a: assert property (
    pcfg_w[9].fn == 2'b10 && pin_in[9] |=> alt_in.edge_event_input_0)
    else $error("edge event input missing");
  data_reset_a: assert property (
    $rose(arst_n) |-> data_q == `GPC_RST_DATA)
    else $error("data register not cleared");
  rsvd_zero_a: assert property (
    s_cfg_write(0, 8'hFF) |=> cfg_q[0] == `GPC_MASK_PLAIN)
    else $error("reserved bits stored");

  sequence s_rd_ack;
    avs_read && st_q == GPC_ACK;
  endsequence

  wait_one_a: assert property (
    req_w && st_q == GPC_IDLE |=> !avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  read_stand_a: assert property (
    s_rd_ack |-> avs_readdata == $past(rdata_d))
    else $error("read data not the addressed value");
  read_high_a: assert property (
    s_rd_ack |-> avs_readdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  in_release_a: assert property (
    pcfg_w[0].dir_in |-> !pin_oe[0])
    else $error("input pin drives");
  drive_level_a: assert property (
    !pcfg_w[0].dir_in && !pcfg_w[0].od |->
      pin_oe[0] && pin_out[0] == (data_q[0] ^ pcfg_w[0].pol))
    else $error("push pull level wrong");
  od_low_only_a: assert property (
    pcfg_w[0].od |-> !pin_out[0])
    else $error("open drain pin drives high");
  fan_off_a: assert property (
    !alt_on_w[5] |=> !alt_in.fan_speed_input_1)
    else $error("fan input 1 active without select");
  fan_two_in_a: assert property (
    alt_on_w[6] && pin_in[6] |=> alt_in.fan_speed_input_2)
    else $error("fan input 2 not routed");
  disp_clk_a: assert property (
    pcfg_w[8].fn == 2'b01 |->
      pin_oe[8] == display_link_clock_5v_low && !pin_out[8])
    else $error("display clock drive wrong");
  disp_data3_a: assert property (
    pcfg_w[9].fn == 2'b01 |->
      pin_oe[9] == display_link_data_3v_low && !pin_out[9])
    else $error("display data 3v drive wrong");
  data_write_a: assert property (
    wr_fire_w && hit_d1_w |=> data_q[6:0] == $past(wdat_w[7:1]))
    else $error("data register write lost");
  cfg_mask_a: assert property (
    wr_fire_w && cfg_hit_w[9] |=>
      cfg_q[9] == ($past(wdat_w) & `GPC_MASK_FN2))
    else $error("config write not masked");

endmodule
`default_nettype wire

// ---- bench/gpc_bank_bench.sv ----
// Self-checking bench for the pin configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "gpc_params.svh"
module gpc_bank_bench
  import gpc_pkg::*;
;
  logic clk_sys;
  logic arst_n;
  logic [9:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [9:0] pin_in;
  logic [9:0] pin_out;
  logic [9:0] pin_oe;
  logic [2:0] low_q;
  gpc_alt_in_s alt_in;
  int err_count;
  int cmp_count;
  logic [31:0] rd;
  logic [7:0] a_idx [8] = '{8'h26, 8'h27, 8'h28, 8'h29, 8'h29, 8'h29,
    8'h2A, 8'h2A};
  logic [7:0] a_cfg [8] = '{8'h05, 8'h05, 8'h05, 8'h05, 8'h09, 8'h0D,
    8'h05, 8'h09};
  logic [5:0] a_exp [8] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h01, 6'h00,
    6'h02, 6'h01};

  gpc_bank dut
  (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe(pin_oe),
    .display_link_data_5v_low(low_q[0]),
    .display_link_clock_5v_low(low_q[1]),
    .display_link_data_3v_low(low_q[2]),
    .alt_in(alt_in)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic wrap_up;
    $display("mismatches %0d, comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] idx,
    input logic [7:0] wd, input logic be);
    int n;
    @(posedge clk_sys);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h000000, wd};
    avs_byteenable <= {3'b000, be};
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0)
    begin
      err_count++;
      $display("BAD %0t bus wait ran out", $time);
      wrap_up();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    bus(1'b1, idx, wd, 1'b1);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00, 1'b1);
    chk(rd, {24'h000000, exp});
  endtask

  task automatic settle;
    @(posedge clk_sys);
    #1;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial
  begin
    logic v;
    logic [7:0] m;
    arst_n = 1'b0;
    avs_address = 10'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h0;
    pin_in = 10'h000;
    low_q = 3'b000;
    err_count = 0;
    cmp_count = 0;
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    for (int i = 0; i < 10; i++)
      rdchk(8'h21 + i, i < 7 ? `GPC_RST_GRP1 : `GPC_RST_GRP2);
    rdchk(`GPC_IDX_DATA_1, 8'h00);
    chk({25'h0, pin_oe[6:0]}, 32'h0);
    for (int i = 0; i < 10; i++)
    begin
      m = i < 5 ? `GPC_MASK_PLAIN : i < 8 ? `GPC_MASK_FN1 : `GPC_MASK_FN2;
      wr(8'h21 + i, 8'hFF);
      rdchk(8'h21 + i, m);
    end
    wr(8'h30, 8'hFF);
    rdchk(8'h30, 8'h00);
    bus(1'b1, `GPC_IDX_PIN_1_1, 8'h00, 1'b0);
    rdchk(`GPC_IDX_PIN_1_1, `GPC_MASK_PLAIN);
    for (int i = 1; i < 10; i++)
      wr(8'h21 + i, 8'h01);
    // Polarity and driver type on pin 1.1 as output
    for (int c = 0; c < 4; c++)
      for (int d = 0; d < 2; d++)
      begin
        v = d[0] ^ c[0];
        wr(`GPC_IDX_PIN_1_1, {c[1], 5'h00, c[0], 1'b0});
        wr(`GPC_IDX_DATA_1, {6'h00, d[0], 1'b0});
        settle();
        chk({31'h0, pin_oe[0]}, {31'h0, c[1] ? ~v : 1'b1});
        chk({31'h0, pin_out[0]}, {31'h0, c[1] ? 1'b0 : v});
      end
    // Output pin reads back its stored bit
    rdchk(`GPC_IDX_DATA_1, 8'h02);
    wr(`GPC_IDX_PIN_1_1, 8'h01);
    @(posedge clk_sys);
    pin_in <= 10'h07F;
    rdchk(`GPC_IDX_DATA_1, 8'hFE);
    chk({31'h0, pin_oe[0]}, 32'h0);
    wr(`GPC_IDX_PIN_1_1, 8'h03);
    rdchk(`GPC_IDX_DATA_1, 8'hFC);
    // Alternate functions, one at a time
    @(posedge clk_sys);
    pin_in <= 10'h3FF;
    settle();
    settle();
    chk({26'h0, alt_in}, 32'h0);
    rdchk(`GPC_IDX_DATA_2, 8'h07);
    for (int k = 0; k < 8; k++)
    begin
      wr(a_idx[k], a_cfg[k]);
      settle();
      settle();
      chk({26'h0, alt_in}, {26'h0, a_exp[k]});
      wr(a_idx[k], 8'h01);
      settle();
      settle();
      chk({26'h0, alt_in}, 32'h0);
    end
    // Display lines driven low only on request
    for (int k = 0; k < 3; k++)
    begin
      wr(8'h28 + k, 8'h05);
      @(posedge clk_sys);
      low_q <= 3'b001 << k;
      settle();
      chk({30'h0, pin_oe[7 + k], pin_out[7 + k]}, 32'h2);
      @(posedge clk_sys);
      low_q <= 3'b000;
      settle();
      chk({31'h0, pin_oe[7 + k]}, 32'h0);
      wr(8'h28 + k, 8'h01);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
